// file: dv/aec_encoder_model.sv
// Purpose: incremental quadrature encoder with index channel, driving the counter's encoder pins
// Assumes: pins change just after a rising clock edge, synchronous to the core clock
// Notes: index idles high (inactive for the reset polarity); moves are called by the testbench
`timescale 1ns/100ps
module aec_encoder_model (
	input wire logic clk_i,
	output logic enc_a_o,
	output logic enc_b_o,
	output logic enc_n_o
);
	logic [1:0] st;

	initial begin
		st = 2'h0;
		enc_a_o = 1'b0;
		enc_b_o = 1'b0;
		enc_n_o = 1'b1;
	end

	// one channel changes per move, so the counter never sees a double change
	task automatic step(input logic fwd, input int gap);
		@(posedge clk_i);
		st = fwd ? st + 2'h1 : st - 2'h1;
		enc_a_o <= st[0] ^ st[1];
		enc_b_o <= st[1];
		repeat (gap) @(posedge clk_i);
	endtask

	task automatic set_n(input logic v);
		@(posedge clk_i);
		enc_n_o <= v;
		repeat (2) @(posedge clk_i);
	endtask
endmodule // aec_encoder_model

// file: dv/testbench.sv
// Purpose: self-checking bench for the encoder position counter over APB
// Assumes: zero-wait APB slave; constant recomputed within 200 cycles of a write
// Notes: expected values are worked out here from the register map and the count rules
`timescale 1ns/100ps
`include "aec_map.svh"
module testbench;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, enc_a, enc_b, enc_n, err;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rd, ea, ec, ed;
	int num_errors, n_checks;
	localparam logic [31:0] clr_v = 32'h0000_1234;
	localparam logic [31:0] clr_b = 32'h0000_0080;
	localparam logic [31:0] cont_b = 32'h0000_0100;
	localparam logic [31:0] once_b = 32'h0000_0200;
	localparam logic [31:0] skip_b = 32'h0000_0040;
	localparam logic [31:0] rise_b = 32'h0000_0010;

	aec_counter u_aec_counter (
		.CORE_CLK_I(clk),
		.NRST_I(nrst),
		.PSEL_I(psel),
		.PENABLE_I(penable),
		.PWRITE_I(pwrite),
		.PADDR_I(paddr),
		.PWDATA_I(pwdata),
		.PRDATA_O(prdata),
		.PREADY_O(pready),
		.PSLVERR_O(pslverr),
		.ENC_A_I(enc_a),
		.ENC_B_I(enc_b),
		.ENC_N_I(enc_n)
	);
	aec_encoder_model u_aec_encoder_model (
		.clk_i(clk),
		.enc_a_o(enc_a),
		.enc_b_o(enc_b),
		.enc_n_o(enc_n)
	);

	always #12.5 clk = ~clk;

	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no wait limit here: the watchdog ends a bus that never answers
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rchk(input string nm, input logic [9:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	task automatic mv(input logic fwd, input int n);
		for (int i = 0; i < n; i++) begin
			u_aec_encoder_model.step(fwd, 1 + i % 3);
		end
	endtask

	task automatic wcal;
		repeat (200) @(posedge clk);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		$display("MISMATCH watchdog expected finish seen timeout");
		end_sim;
	end

	initial begin
		clk = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h0;
		pwdata = 32'h0;
		num_errors = 0;
		n_checks = 0;
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		rchk("cfg reset", `AEC_ADDR_CFG, 32'h0);
		rchk("step reset", `AEC_ADDR_STEP, 32'h0);
		rchk("pos reset", `AEC_ADDR_POS, 32'h0);
		rchk("const reset", `AEC_ADDR_RES, 32'h0);
		rchk("unmapped data", 10'h3fc, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		$display("test reset done");
		// 256 microsteps x 200 fullsteps over 4000 gives 12.8: exact only in decimal
		apb(1'b1, `AEC_ADDR_STEP, 32'h0100_00c8);
		apb(1'b1, `AEC_ADDR_RES, 32'd4000);
		wcal;
		rchk("const dec", `AEC_ADDR_RES, 32'h000c_1f40);
		apb(1'b1, `AEC_ADDR_POS, 32'h0);
		mv(1'b1, 5);
		rchk("pos dec", `AEC_ADDR_POS, 32'd64);
		apb(1'b1, `AEC_ADDR_RES, 32'd1024);
		wcal;
		rchk("const bin", `AEC_ADDR_RES, 32'h0032_0000);
		// 200 over 3 fits neither format, so the format bit decides
		apb(1'b1, `AEC_ADDR_STEP, 32'h0001_00c8);
		apb(1'b1, `AEC_ADDR_RES, 32'd3);
		wcal;
		apb(1'b0, `AEC_ADDR_RES, 32'h0);
		chk("const int", 32'd66, {17'h0, rd[30:16]});
		chk("frac bin", 32'h1, {31'h0, rd[15:0] >= 16'h2710});
		apb(1'b1, `AEC_ADDR_CFG, 32'h1);
		wcal;
		apb(1'b0, `AEC_ADDR_RES, 32'h0);
		chk("frac dec", 32'h1, {31'h0, rd[15:0] < 16'h2710});
		$display("test auto constant done");
		apb(1'b1, `AEC_ADDR_CFG, 32'h0);
		apb(1'b1, `AEC_ADDR_RES, 32'h8005_0000);
		wcal;
		rchk("const manual", `AEC_ADDR_RES, 32'h0005_0000);
		apb(1'b1, `AEC_ADDR_POS, 32'h0);
		mv(1'b1, 4);
		rchk("pos up", `AEC_ADDR_POS, 32'd20);
		mv(1'b0, 6);
		rchk("pos down", `AEC_ADDR_POS, 32'hffff_fff6);
		mv(1'b1, 1);
		$display("test manual constant done");
		apb(1'b1, `AEC_ADDR_RES, 32'h8001_0000);
		apb(1'b1, `AEC_ADDR_CLR, clr_v);
		apb(1'b1, `AEC_ADDR_CFG, clr_b | cont_b | rise_b);
		wcal;
		apb(1'b1, `AEC_ADDR_POS, 32'd100);
		u_aec_encoder_model.set_n(1'b0);
		rchk("clr qualified", `AEC_ADDR_POS, clr_v);
		u_aec_encoder_model.set_n(1'b1);
		mv(1'b1, 1);
		u_aec_encoder_model.set_n(1'b0);
		rchk("a not qualified", `AEC_ADDR_POS, clr_v + 1);
		u_aec_encoder_model.set_n(1'b1);
		apb(1'b1, `AEC_ADDR_CFG, clr_b | cont_b | rise_b | 32'h2);
		u_aec_encoder_model.set_n(1'b0);
		rchk("a high qualify", `AEC_ADDR_POS, clr_v);
		u_aec_encoder_model.set_n(1'b1);
		mv(1'b1, 1);
		// now A and B both high: B must be qualified as well
		u_aec_encoder_model.set_n(1'b0);
		rchk("b not qualified", `AEC_ADDR_POS, clr_v + 1);
		u_aec_encoder_model.set_n(1'b1);
		apb(1'b1, `AEC_ADDR_CFG, clr_b | cont_b | rise_b | 32'h6);
		u_aec_encoder_model.set_n(1'b0);
		rchk("b high qualify", `AEC_ADDR_POS, clr_v);
		u_aec_encoder_model.set_n(1'b1);
		mv(1'b1, 1);
		apb(1'b1, `AEC_ADDR_CFG, clr_b | cont_b | rise_b | skip_b);
		u_aec_encoder_model.set_n(1'b0);
		rchk("skip qualify", `AEC_ADDR_POS, clr_v);
		u_aec_encoder_model.set_n(1'b1);
		$display("test qualify done");
		for (int p = 0; p < 2; p++) begin
			for (int m = 0; m < 4; m++) begin
				u_aec_encoder_model.set_n(~p[0]);
				apb(1'b1, `AEC_ADDR_CFG, clr_b | cont_b | skip_b | 32'(m << 4) | 32'(p << 3));
				apb(1'b1, `AEC_ADDR_POS, 32'd7);
				ea = (m == 2) ? 32'd7 : clr_v;
				ec = (m == 0) ? clr_v : ea + 1;
				ed = (m >= 2) ? clr_v : ec;
				u_aec_encoder_model.set_n(p[0]);
				rchk("sens active", `AEC_ADDR_POS, ea);
				mv(1'b1, 1);
				rchk("sens moved", `AEC_ADDR_POS, ec);
				u_aec_encoder_model.set_n(~p[0]);
				rchk("sens inactive", `AEC_ADDR_POS, ed);
			end
		end
		$display("test sensitivity done");
		// index low would be active under the low-active polarity and spend the once bit early
		u_aec_encoder_model.set_n(1'b1);
		apb(1'b1, `AEC_ADDR_CFG, clr_b | once_b | skip_b | rise_b);
		apb(1'b1, `AEC_ADDR_POS, 32'd50);
		u_aec_encoder_model.set_n(1'b0);
		rchk("once clear", `AEC_ADDR_POS, clr_v);
		rchk("once bit", `AEC_ADDR_CFG, clr_b | skip_b | rise_b);
		u_aec_encoder_model.set_n(1'b1);
		mv(1'b0, 1);
		u_aec_encoder_model.set_n(1'b0);
		rchk("once spent", `AEC_ADDR_POS, clr_v - 1);
		u_aec_encoder_model.set_n(1'b1);
		$display("test once done");
		apb(1'b1, `AEC_ADDR_CFG, 32'h0000_0400 | cont_b | skip_b | rise_b);
		apb(1'b1, `AEC_ADDR_POS, 32'h77);
		u_aec_encoder_model.set_n(1'b0);
		rchk("latch", `AEC_ADDR_CLR, 32'h77);
		rchk("latch no clear", `AEC_ADDR_POS, 32'h77);
		u_aec_encoder_model.set_n(1'b1);
		$display("test latch done");
		end_sim;
	end
endmodule // testbench

// file: inc/aec_map.svh
// Purpose: register indexes, field positions, reset values and constants of the encoder counter
// Assumes: 32-bit APB data, one register per aligned word at byte address four times its index
// Notes: definitions only
`ifndef AEC_MAP_SVH
`define AEC_MAP_SVH

`define AEC_IDX_CFG 7'h07
`define AEC_IDX_STEP 7'h0a
`define AEC_IDX_POS 7'h50
`define AEC_IDX_CLR 7'h51
`define AEC_IDX_RES 7'h54

`define AEC_ADDR_CFG {1'b0, `AEC_IDX_CFG, 2'b00}
`define AEC_ADDR_STEP {1'b0, `AEC_IDX_STEP, 2'b00}
`define AEC_ADDR_POS {1'b0, `AEC_IDX_POS, 2'b00}
`define AEC_ADDR_CLR {1'b0, `AEC_IDX_CLR, 2'b00}
`define AEC_ADDR_RES {1'b0, `AEC_IDX_RES, 2'b00}

// encoder_config fields
`define AEC_CFG_FMT 0
`define AEC_CFG_POL_A 1
`define AEC_CFG_POL_B 2
`define AEC_CFG_POL_N 3
`define AEC_CFG_SENS_LSB 4
`define AEC_CFG_SENS_MSB 5
`define AEC_CFG_SKIP_AB 6
`define AEC_CFG_CLR_ON_N 7
`define AEC_CFG_CONT 8
`define AEC_CFG_ONCE 9
`define AEC_CFG_LATCH_ON_N 10

// step_resolution_config fields
`define AEC_STEP_FS_LSB 0
`define AEC_STEP_FS_MSB 15
`define AEC_STEP_MS_LSB 16
`define AEC_STEP_MS_MSB 25

`define AEC_RES_MANUAL 31

`define AEC_RST_CFG 32'h0000_0000
`define AEC_RST_STEP 32'h0000_0000
`define AEC_RST_RES 32'h0000_0000
`define AEC_RST_WORD 32'h0000_0000

// fraction moduli: 16 binary places, or decimal places counted in ten-thousandths
`define AEC_MOD_BIN 17'h10000
`define AEC_MOD_DEC 17'h02710
`define AEC_DEC_SCALE 48'h0000_0000_2710

`endif

// file: inc/aec_pkg.sv
// Purpose: types shared by the encoder counter design
// Assumes: nothing beyond SystemVerilog
// Notes: constants live in aec_map.svh
package aec_pkg;
	typedef enum logic [3:0] {
		AEC_IDLE = 4'h1,
		AEC_BIN = 4'h2,
		AEC_DEC = 4'h4,
		AEC_DONE = 4'h8
	} aec_calc_t;

	typedef enum logic [5:0] {
		AEC_REG_NONE = 6'h01,
		AEC_REG_CFG = 6'h02,
		AEC_REG_STEP = 6'h04,
		AEC_REG_POS = 6'h08,
		AEC_REG_CLR = 6'h10,
		AEC_REG_RES = 6'h20
	} aec_reg_t;
endpackage

// file: rtl/aec_counter.sv
// Purpose: quadrature encoder position counter with index event, clear and latch
// Assumes: encoder inputs already synchronous to CORE_CLK_I; APB3 slave without pstrb
// Notes: zero-wait APB answer; constant recomputed after writes to its inputs
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`include "aec_map.svh"

// Overview of operation
// - every A or B level change, except A and B changing at once, moves the external position counter
// - each change moves by the constant; auto constant is microsteps times fullsteps over resolution
// - constant is fixed point, 15 integer and 16 fraction bits, read at resolution offset
// - inexact binary fraction falls back to exact ten-thousandths when that fits
// - format bit 0 picks binary (0) or decimal (1) fraction for a manual constant, or when neither fits exactly
// - resolution bit 31 set makes bits 30:0 the constant directly
// - index is active low after reset; polarity bit 3 makes it active high
// - sensitivity 00 level, 01 into active, 10 into inactive, 11 both edges
// - index event also needs A and B at their qualifying levels, default low
// - skip-qualify bit forms the index event from the index channel alone
// - clearing loads the programmable clear value, not only zero
// - clear on index with continuous bit loads the clear value every event
// - once bit clears on the next event only, then resets itself
// - latch on index copies the position into the read-only latch, same selection
module aec_counter #(
	parameter int AW = 10
) (
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [AW-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic ENC_A_I,
	input wire logic ENC_B_I,
	input wire logic ENC_N_I
);
	localparam int DW = 48;

	function automatic aec_pkg::aec_reg_t decode(input logic [AW-1:0] addr);
		case (addr)
			AW'(`AEC_ADDR_CFG): decode = aec_pkg::AEC_REG_CFG;
			AW'(`AEC_ADDR_STEP): decode = aec_pkg::AEC_REG_STEP;
			AW'(`AEC_ADDR_POS): decode = aec_pkg::AEC_REG_POS;
			AW'(`AEC_ADDR_CLR): decode = aec_pkg::AEC_REG_CLR;
			AW'(`AEC_ADDR_RES): decode = aec_pkg::AEC_REG_RES;
			default: decode = aec_pkg::AEC_REG_NONE;
		endcase
	endfunction

	logic [31:0] encoder_config_q;
	logic [31:0] step_resolution_config_q;
	logic [31:0] encoder_resolution_q;
	logic [31:0] index_clear_value_q;
	logic [31:0] pos_q;
	logic [15:0] frac_q;
	logic [31:0] latch_q;
	logic [30:0] const_q;
	logic const_dec_q;
	logic a_prev_q;
	logic b_prev_q;
	logic n_prev_q;
	logic recalc_q;
	aec_pkg::aec_calc_t calc_q;
	logic div_start_q;
	logic [25:0] num_q;
	logic [47:0] bin_q;
	logic bin_exact_q;
	logic div_done;
	logic [DW-1:0] div_quot;
	logic [31:0] div_rem;

	// bus decode
	aec_pkg::aec_reg_t sel;
	logic acc_done;
	logic wr_cfg;
	logic wr_step;
	logic wr_pos;
	logic wr_clr;
	logic wr_res;

	assign sel = decode(PADDR_I);
	assign acc_done = PSEL_I && PENABLE_I && PREADY_O;
	assign wr_cfg = acc_done && PWRITE_I && (sel == aec_pkg::AEC_REG_CFG);
	assign wr_step = acc_done && PWRITE_I && (sel == aec_pkg::AEC_REG_STEP);
	assign wr_pos = acc_done && PWRITE_I && (sel == aec_pkg::AEC_REG_POS);
	assign wr_clr = acc_done && PWRITE_I && (sel == aec_pkg::AEC_REG_CLR);
	assign wr_res = acc_done && PWRITE_I && (sel == aec_pkg::AEC_REG_RES);

	// effective constant: manual word or the computed one
	logic manual;
	logic [14:0] k_int;
	logic [15:0] k_frac;
	logic k_dec;
	logic [30:0] const_rd;

	assign manual = encoder_resolution_q[`AEC_RES_MANUAL];
	assign const_rd = manual ? encoder_resolution_q[30:0] : const_q;
	assign k_int = const_rd[30:16];
	assign k_frac = const_rd[15:0];
	assign k_dec = manual ? encoder_config_q[`AEC_CFG_FMT] : const_dec_q;

	// quadrature decode
	logic a_chg;
	logic b_chg;
	logic move;
	logic up;

	assign a_chg = ENC_A_I ^ a_prev_q;
	assign b_chg = ENC_B_I ^ b_prev_q;
	// a change of both lines at once has no direction and is dropped
	assign move = a_chg ^ b_chg;
	assign up = ENC_A_I ^ b_prev_q;

	logic [16:0] modulus;
	logic [16:0] fsum;
	logic carry;
	logic [31:0] pos_step;
	logic [15:0] frac_step;

	always_comb begin
		modulus = k_dec ? `AEC_MOD_DEC : `AEC_MOD_BIN;
		carry = 1'b0;
		if (up) begin
			fsum = {1'b0, frac_q} + {1'b0, k_frac};
			carry = fsum >= modulus;
			frac_step = carry ? 16'(fsum - modulus) : fsum[15:0];
			pos_step = pos_q + {17'h00000, k_int} + {31'h0, carry};
		end else begin
			fsum = {1'b0, frac_q} - {1'b0, k_frac};
			carry = fsum[16];
			frac_step = carry ? 16'(fsum + modulus) : fsum[15:0];
			pos_step = pos_q - {17'h00000, k_int} - {31'h0, carry};
		end
	end

	// index event
	logic n_act;
	logic n_raw;
	logic qualify;
	logic index_evt;
	logic armed;
	logic act;

	assign n_act = ENC_N_I ~^ encoder_config_q[`AEC_CFG_POL_N];
	always_comb begin
		case (encoder_config_q[`AEC_CFG_SENS_MSB:`AEC_CFG_SENS_LSB])
			2'h0: n_raw = n_act;
			2'h1: n_raw = n_act && !n_prev_q;
			2'h2: n_raw = !n_act && n_prev_q;
			2'h3: n_raw = n_act ^ n_prev_q;
			default: n_raw = 1'b0;
		endcase
	end
	assign qualify = encoder_config_q[`AEC_CFG_SKIP_AB]
		|| ((ENC_A_I == encoder_config_q[`AEC_CFG_POL_A])
		&& (ENC_B_I == encoder_config_q[`AEC_CFG_POL_B]));
	assign index_evt = n_raw && qualify;
	assign armed = encoder_config_q[`AEC_CFG_CONT] || encoder_config_q[`AEC_CFG_ONCE];
	assign act = index_evt && armed;

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			a_prev_q <= 1'b0;
			b_prev_q <= 1'b0;
			n_prev_q <= 1'b0;
		end else begin
			a_prev_q <= ENC_A_I;
			b_prev_q <= ENC_B_I;
			n_prev_q <= n_act;
		end
	end

	// configuration; a software write in the event cycle wins so a fresh arming is kept
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			encoder_config_q <= `AEC_RST_CFG;
		end else if (wr_cfg) begin
			encoder_config_q <= PWDATA_I;
		end else if (act && !encoder_config_q[`AEC_CFG_CONT]) begin
			encoder_config_q[`AEC_CFG_ONCE] <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			step_resolution_config_q <= `AEC_RST_STEP;
			encoder_resolution_q <= `AEC_RST_RES;
			index_clear_value_q <= `AEC_RST_WORD;
		end else begin
			if (wr_step) begin
				step_resolution_config_q <= PWDATA_I;
			end
			if (wr_res) begin
				encoder_resolution_q <= PWDATA_I;
			end
			if (wr_clr) begin
				index_clear_value_q <= PWDATA_I;
			end
		end
	end

	// position counter: index clear beats a software write, which beats a step
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			pos_q <= `AEC_RST_WORD;
			frac_q <= 16'h0000;
		end else if (act && encoder_config_q[`AEC_CFG_CLR_ON_N]) begin
			pos_q <= index_clear_value_q;
			frac_q <= 16'h0000;
		end else if (wr_pos) begin
			pos_q <= PWDATA_I;
			frac_q <= 16'h0000;
		end else if (move) begin
			pos_q <= pos_step;
			frac_q <= frac_step;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			latch_q <= `AEC_RST_WORD;
		end else if (act && encoder_config_q[`AEC_CFG_LATCH_ON_N]) begin
			latch_q <= pos_q;
		end
	end

	// constant calculation; a request during a run is kept and served afterwards
	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			recalc_q <= 1'b0;
		end else if (wr_step || wr_res || wr_cfg) begin
			recalc_q <= 1'b1;
		end else if (calc_q == aec_pkg::AEC_IDLE) begin
			recalc_q <= 1'b0;
		end
	end

	logic [DW-1:0] dividend;
	logic [47:0] dec_frac;
	logic res_zero;

	// the divider takes its dividend one cycle after the state has moved on
	assign dividend = (calc_q == aec_pkg::AEC_BIN) ? {6'h00, num_q, 16'h0000}
		: 48'(num_q) * `AEC_DEC_SCALE;
	assign dec_frac = div_quot - bin_q[47:16] * `AEC_DEC_SCALE;
	assign res_zero = encoder_resolution_q[30:0] == 31'h0;

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			calc_q <= aec_pkg::AEC_IDLE;
			div_start_q <= 1'b0;
			num_q <= 26'h0000000;
			bin_q <= 48'h0;
			bin_exact_q <= 1'b0;
			const_q <= 31'h0;
			const_dec_q <= 1'b0;
		end else begin
			div_start_q <= 1'b0;
			case (calc_q)
				aec_pkg::AEC_IDLE: begin
					num_q <= 26'(step_resolution_config_q[`AEC_STEP_MS_MSB:`AEC_STEP_MS_LSB]
						* step_resolution_config_q[`AEC_STEP_FS_MSB:`AEC_STEP_FS_LSB]);
					if (recalc_q) begin
						calc_q <= aec_pkg::AEC_BIN;
					end
				end
				aec_pkg::AEC_BIN: begin
					if (res_zero) begin
						const_q <= 31'h0;
						const_dec_q <= 1'b0;
						calc_q <= aec_pkg::AEC_IDLE;
					end else if (div_done && !div_start_q) begin
						// a done pulse left from a run abandoned on zero resolution is not ours
						bin_q <= div_quot;
						bin_exact_q <= div_rem == 32'h0;
						div_start_q <= 1'b1;
						calc_q <= aec_pkg::AEC_DEC;
					end
				end
				aec_pkg::AEC_DEC: begin
					if (div_done) begin
						calc_q <= aec_pkg::AEC_DONE;
						// exact binary wins; else exact decimal; else the format bit
						if (bin_q[47:31] != 17'h0) begin
							const_q <= 31'h7fff_ffff;
							const_dec_q <= 1'b0;
						end else if (!bin_exact_q
							&& (div_rem == 32'h0 || encoder_config_q[`AEC_CFG_FMT])) begin
							const_q <= {bin_q[30:16], dec_frac[15:0]};
							const_dec_q <= 1'b1;
						end else begin
							const_q <= bin_q[30:0];
							const_dec_q <= 1'b0;
						end
					end
				end
				aec_pkg::AEC_DONE: begin
					calc_q <= aec_pkg::AEC_IDLE;
				end
				default: calc_q <= aec_pkg::AEC_IDLE;
			endcase
			if (calc_q == aec_pkg::AEC_IDLE && recalc_q) begin
				div_start_q <= 1'b1;
			end
		end
	end

	aec_divider #(
		.DW(DW),
		.VW(32)
	) u_div (
		.clk_i(CORE_CLK_I),
		.nrst_i(NRST_I),
		.start_i(div_start_q),
		.dividend_i(dividend),
		.divisor_i({1'b0, encoder_resolution_q[30:0]}),
		.done_o(div_done),
		.quot_o(div_quot),
		.rem_o(div_rem)
	);

	// APB slave: answer in the first access cycle
	logic [31:0] rd_d;
	always_comb begin
		case (sel)
			aec_pkg::AEC_REG_CFG: rd_d = encoder_config_q;
			aec_pkg::AEC_REG_STEP: rd_d = step_resolution_config_q;
			aec_pkg::AEC_REG_POS: rd_d = pos_q;
			aec_pkg::AEC_REG_CLR: rd_d = latch_q;
			aec_pkg::AEC_REG_RES: rd_d = {1'b0, const_rd};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PREADY_O <= 1'b0;
			PRDATA_O <= 32'h0000_0000;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O <= PSEL_I && !PENABLE_I;
			if (PSEL_I && !PENABLE_I) begin
				PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_d;
				PSLVERR_O <= sel == aec_pkg::AEC_REG_NONE;
			end
		end
	end

	// checks
	logic [31:0] k32;
	assign k32 = {17'h00000, k_int};

	property p_move;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		move && !act && !wr_pos && k_int != 15'h0 |=> pos_q != $past(pos_q);
	endproperty
	a_move: assert property (p_move) else $error("transition left position unchanged");

	property p_up;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		move && up && !act && !wr_pos && k_frac == 16'h0 && frac_q == 16'h0
			|=> pos_q == $past(pos_q) + $past(k32);
	endproperty
	a_up: assert property (p_up) else $error("A-leading step did not add constant");

	property p_down;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		move && !up && !act && !wr_pos && k_frac == 16'h0 && frac_q == 16'h0
			|=> pos_q == $past(pos_q) - $past(k32);
	endproperty
	a_down: assert property (p_down) else $error("B-leading step did not subtract");

	property p_clear;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		act && encoder_config_q[`AEC_CFG_CLR_ON_N] |=> pos_q == $past(index_clear_value_q);
	endproperty
	a_clear: assert property (p_clear) else $error("index did not load clear value");

	property p_once;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		act && !encoder_config_q[`AEC_CFG_CONT] && !wr_cfg |=> !encoder_config_q[`AEC_CFG_ONCE];
	endproperty
	a_once: assert property (p_once) else $error("once bit survived its event");

	property p_latch;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		act && encoder_config_q[`AEC_CFG_LATCH_ON_N] |=> latch_q == $past(pos_q);
	endproperty
	a_latch: assert property (p_latch) else $error("latch missed the position");

	property p_qualify;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		!encoder_config_q[`AEC_CFG_SKIP_AB] && ENC_A_I != encoder_config_q[`AEC_CFG_POL_A]
			|-> !index_evt;
	endproperty
	a_qualify: assert property (p_qualify) else $error("index event without A qualify");

	property p_edge;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		encoder_config_q[`AEC_CFG_SENS_MSB:`AEC_CFG_SENS_LSB] == 2'h1 && qualify
			&& $rose(ENC_N_I ~^ encoder_config_q[`AEC_CFG_POL_N]) && $stable(encoder_config_q)
			|-> index_evt;
	endproperty
	a_edge: assert property (p_edge) else $error("edge into active gave no event");

	property p_cont;
		@(posedge CORE_CLK_I) disable iff (!NRST_I)
		index_evt && encoder_config_q[`AEC_CFG_CONT] && encoder_config_q[`AEC_CFG_CLR_ON_N]
			|=> pos_q == $past(index_clear_value_q);
	endproperty
	a_cont: assert property (p_cont) else $error("continuous mode dropped");

	c_clear: cover property (@(posedge CORE_CLK_I) act && encoder_config_q[`AEC_CFG_CLR_ON_N]);
	c_latch: cover property (@(posedge CORE_CLK_I) act && encoder_config_q[`AEC_CFG_LATCH_ON_N]);
	c_dec: cover property (@(posedge CORE_CLK_I) move && k_dec && carry);
	c_calc: cover property (@(posedge CORE_CLK_I) calc_q == aec_pkg::AEC_DONE);
endmodule // aec_counter

// file: rtl/aec_divider.sv
// Purpose: sequential restoring divider for the transition constant
// Assumes: start only while idle; divisor nonzero (caller handles zero)
// Notes: one quotient bit per clock, DW clocks from start to done
`timescale 1ns/100ps
module aec_divider #(
	parameter int DW = 48,
	parameter int VW = 32
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic start_i,
	input wire logic [DW-1:0] dividend_i,
	input wire logic [VW-1:0] divisor_i,
	output logic done_o,
	output logic [DW-1:0] quot_o,
	output logic [VW-1:0] rem_o
);
	localparam int CW = $clog2(DW + 1);
	logic [CW-1:0] cnt_q;
	logic [VW-1:0] div_q;
	logic [VW:0] shifted;
	logic take;

	assign shifted = {rem_o, quot_o[DW-1]};
	assign take = shifted >= {1'b0, div_q};

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= '0;
			div_q <= '0;
			quot_o <= '0;
			rem_o <= '0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				cnt_q <= CW'(DW);
				div_q <= divisor_i;
				quot_o <= dividend_i;
				rem_o <= '0;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
				quot_o <= {quot_o[DW-2:0], take};
				// a remainder below the divisor always fits VW bits
				rem_o <= take ? VW'(shifted - {1'b0, div_q}) : shifted[VW-1:0];
				done_o <= (cnt_q == CW'(1));
			end
		end
	end
endmodule // aec_divider
